// file: common/pcrb_defines.svh
`ifndef PCRB_DEFINES_SVH
`define PCRB_DEFINES_SVH

// Register offsets, one byte each.
`define PCRB_OFS_REF_DIVIDER_LOW                 3'h0
`define PCRB_OFS_REF_DIVIDER_HIGH_AND_CONTROL    3'h1
`define PCRB_OFS_POST_DIVIDER_ONE_TWO            3'h2
`define PCRB_OFS_FEEDBACK_DIVIDER_LOW            3'h3
`define PCRB_OFS_FEEDBACK_DIVIDER_HIGH_AND_OUTPUT 3'h4
`define PCRB_OFS_LOOP_TUNING                     3'h5
`define PCRB_OFS_SHUTDOWN_AND_SYNC_CONTROL       3'h6
`define PCRB_OFS_RESERVED_TOP_BYTE               3'h7

// Bank shape and power-up value.
`define PCRB_CFG_WIDTH        64
`define PCRB_CFG_RESET        64'h0000_0000_0000_0000

// Field positions within the 64-bit bank.
`define PCRB_REF_LEN_LSB      0
`define PCRB_REF_LEN_W        12
`define PCRB_REF_SRC_BIT      12
`define PCRB_SHUTDOWN_ONE_BIT 13
`define PCRB_POST_THREE_LSB   14
`define PCRB_POST_ONE_LSB     16
`define PCRB_POST_TWO_LSB     20
`define PCRB_FBK_LEN_LSB      24
`define PCRB_FBK_LEN_W        14
`define PCRB_FBK_SRC_BIT      38
`define PCRB_CMOS_MODE_BIT    39
`define PCRB_PUMP_CODE_LSB    40
`define PCRB_RES_CODE_LSB     44
`define PCRB_CAP_SEL_BIT      46
`define PCRB_SYNC_EN_BIT      48
`define PCRB_SYNC_POL_BIT     49
`define PCRB_SHUTDOWN_TWO_BIT 53

// Serial protocol counts.
`define PCRB_BITS_PER_BYTE    4'h8

`endif

// file: common/pcrb_pkg.sv
`default_nettype none
package pcrb_pkg;
	typedef enum logic [8:0] {
		PCRB_IDLE     = 9'h001,
		PCRB_DEV_ADDR = 9'h002,
		PCRB_ACK_DEV  = 9'h004,
		PCRB_REG_ADDR = 9'h008,
		PCRB_ACK_REG  = 9'h010,
		PCRB_WR_DATA  = 9'h020,
		PCRB_ACK_WR   = 9'h040,
		PCRB_RD_DATA  = 9'h080,
		PCRB_RD_ACK   = 9'h100
	} pcrb_state_t;

	typedef struct packed {
		pcrb_state_t state;
		logic [3:0]  cnt;
		logic [7:0]  shreg;
		logic [2:0]  ptr;
		logic        rw;
		logic        sda_drive;
		logic [63:0] cfg;
		logic        ref_div_in;
		logic        fbk_div_in;
		logic        sync_pulse;
	} pcrb_top_state_t;

	typedef struct packed {
		logic prev;
	} pcrb_edge_state_t;

	typedef struct packed {
		logic [3:0] pump_sel;
		logic [3:0] res_sel;
		logic       cap_large;
		logic [4:0] post_one_mod;
		logic [4:0] post_two_mod;
		logic [3:0] post_three_mod;
	} pcrb_dec_state_t;
endpackage
`default_nettype wire

// file: hdl/pcrb_edge_detect.sv
`timescale 1ns/1ns
`default_nettype none
module pcrb_edge_detect #(
	parameter logic RESET_LEVEL = 1'b0
) (
	input  wire logic clk_sys,   // system clock
	input  wire logic rstn,      // synchronous reset, active low
	input  wire logic level_in,  // sampled level
	output logic      rise,      // level went 0 to 1
	output logic      fall       // level went 1 to 0
);
	import pcrb_pkg::*;

	pcrb_edge_state_t r_reg;
	pcrb_edge_state_t r_next;

	always_comb
	begin
		r_next = r_reg;
		r_next.prev = level_in;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
			r_reg <= '{prev: RESET_LEVEL};
		else
			r_reg <= r_next;
	end

	assign rise = level_in & ~r_reg.prev;
	assign fall = ~level_in & r_reg.prev;
endmodule // pcrb_edge_detect
`default_nettype wire

// file: hdl/pcrb_field_decode.sv
`timescale 1ns/1ns
`default_nettype none
module pcrb_field_decode (
	input  wire logic       clk_sys,         // system clock
	input  wire logic       rstn,            // synchronous reset, active low
	input  wire logic [1:0] pump_code,       // pump current code
	input  wire logic [1:0] res_code,        // loop resistor code
	input  wire logic       cap_code,        // loop capacitor select
	input  wire logic [3:0] post_one_code,   // first post stage code
	input  wire logic [3:0] post_two_code,   // second post stage code
	input  wire logic [1:0] post_three_code, // third post stage code
	output logic      [3:0] pump_sel,        // one-hot 2.0/4.5/11.0/22.5 uA
	output logic      [3:0] res_sel,         // one-hot 400k/133k/30k/12k
	output logic            cap_large,       // 1 selects 500 pF, 0 185 pF
	output logic      [4:0] post_one_mod,    // first post modulus
	output logic      [4:0] post_two_mod,    // second post modulus
	output logic      [3:0] post_three_mod   // third post modulus
);
	import pcrb_pkg::*;

	pcrb_dec_state_t r_reg;
	pcrb_dec_state_t r_next;

	always_comb
	begin
		r_next = r_reg;
		// R07 pump current decode
		r_next.pump_sel = 4'h1 << pump_code;
		// R08 resistor decode
		r_next.res_sel = 4'h1 << res_code;
		// R09 capacitor select
		r_next.cap_large = cap_code;
		// R12 modulus plus one
		r_next.post_one_mod = {1'b0, post_one_code} + 5'h01;
		r_next.post_two_mod = {1'b0, post_two_code} + 5'h01;
		// R13 power-of-two modulus
		r_next.post_three_mod = 4'h1 << post_three_code;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
			r_reg <= '{pump_sel: 4'h1, res_sel: 4'h1, cap_large: 1'b0,
				post_one_mod: 5'h01, post_two_mod: 5'h01, post_three_mod: 4'h1};
		else
			r_reg <= r_next;
	end

	assign pump_sel       = r_reg.pump_sel;
	assign res_sel        = r_reg.res_sel;
	assign cap_large      = r_reg.cap_large;
	assign post_one_mod   = r_reg.post_one_mod;
	assign post_two_mod   = r_reg.post_two_mod;
	assign post_three_mod = r_reg.post_three_mod;
endmodule // pcrb_field_decode
`default_nettype wire

// file: hdl/pcrb_top.sv
// How it works
// R01: Host writes zero to all reserved bits.
// R02: Reference source bit picks crystal or pin.
// R03: Feedback source bit picks oscillator or post.
// R04: First shutdown bit powers circuitry down.
// R05: Second shutdown bit powers circuitry down.
// R06: Output mode bit picks PECL or CMOS.
// R07: Pump code decodes to four currents.
// R08: Resistor code decodes to four resistors.
// R09: Capacitor bit picks 185 or 500 pF.
// R10: Reference length is twelve binary bits.
// R11: Feedback length is fourteen binary bits.
// R12: First two post stages divide by N+1.
// R13: Third post stage divides by 1,2,4,8.
// R14: Sync input ignored unless enabled.
// R15: Polarity bit picks falling or rising edge.
// R16: Every configuration bit clears at power-up.
// R17: Reads return exactly what was written.
// R18: Byte pointer advances and wraps after eight.
// R19: Fields drive logic continuously once written.
`timescale 1ns/1ns
`default_nettype none
`include "pcrb_defines.svh"
module pcrb_top #(
	parameter logic [4:0] DEV_ADDR_HIGH = 5'h14 // arbitrary upper address bits
) (
	input  wire logic        clk_sys,                  // system clock
	input  wire logic        rstn,                     // synchronous reset, active low
	input  wire logic        scl_in,                   // serial clock level
	input  wire logic        sda_in,                   // serial data level
	output logic             sda_out,                  // serial data driven value
	output logic             sda_oe,                   // serial data drive enable
	input  wire logic        addr_sel0,                // address strap bit 0
	input  wire logic        addr_sel1,                // address strap bit 1
	input  wire logic        sync_in,                  // sync input
	input  wire logic        osc_in,                   // crystal oscillator clock
	input  wire logic        ref_pin_in,               // external reference clock
	input  wire logic        vco_in,                   // oscillator output clock
	input  wire logic        post_div_in,              // post divider output clock
	output logic             ref_div_in,               // reference divider feed
	output logic             fbk_div_in,               // feedback divider feed
	output logic [11:0]      ref_divide_length,        // reference divider length
	output logic [13:0]      feedback_divide_length,   // feedback divider length
	output logic             ref_source_select,        // 1 selects reference pin
	output logic             feedback_source_select,   // 1 selects post output
	output logic             shutdown_first,           // 1 powers first group down
	output logic             shutdown_second,          // 1 powers second group down
	output logic             cmos_output_mode,         // 1 CMOS, 0 PECL outputs
	output logic [1:0]       pump_current_code,        // pump current code
	output logic [1:0]       loop_resistor_code,       // loop resistor code
	output logic             loop_capacitor_select,    // loop capacitor select
	output logic [3:0]       post_stage_one_code,      // first post stage code
	output logic [3:0]       post_stage_two_code,      // second post stage code
	output logic [1:0]       post_stage_three_code,    // third post stage code
	output logic             sync_input_enable,        // sync enable
	output logic             sync_edge_polarity,       // 1 rising, 0 falling
	output logic [3:0]       pump_current_sel,         // one-hot current choice
	output logic [3:0]       loop_resistor_sel,        // one-hot resistor choice
	output logic             loop_cap_large,           // 1 selects 500 pF
	output logic [4:0]       post_one_modulus,         // first post modulus
	output logic [4:0]       post_two_modulus,         // second post modulus
	output logic [3:0]       post_three_modulus,       // third post modulus
	output logic             sync_event                // one-cycle sync edge pulse
);
	import pcrb_pkg::*;

	pcrb_top_state_t r_reg;
	pcrb_top_state_t r_next;

	logic scl_rise;
	logic scl_fall;
	logic sda_rise;
	logic sda_fall;
	logic sync_rise;
	logic sync_fall;
	logic start_seen;
	logic stop_seen;
	logic addr_match;
	logic [7:0] rd_byte;

	pcrb_edge_detect #(
		.RESET_LEVEL (1'b1)
	) u_scl_edge (
		.clk_sys  (clk_sys),
		.rstn     (rstn),
		.level_in (scl_in),
		.rise     (scl_rise),
		.fall     (scl_fall)
	);

	pcrb_edge_detect #(
		.RESET_LEVEL (1'b1)
	) u_sda_edge (
		.clk_sys  (clk_sys),
		.rstn     (rstn),
		.level_in (sda_in),
		.rise     (sda_rise),
		.fall     (sda_fall)
	);

	pcrb_edge_detect #(
		.RESET_LEVEL (1'b0)
	) u_sync_edge (
		.clk_sys  (clk_sys),
		.rstn     (rstn),
		.level_in (sync_in),
		.rise     (sync_rise),
		.fall     (sync_fall)
	);

	// Bus conditions: a data change while the clock is high is a start or stop.
	assign start_seen = sda_fall & scl_in;
	assign stop_seen  = sda_rise & scl_in;
	assign addr_match = (r_reg.shreg[7:1] == {DEV_ADDR_HIGH, addr_sel1, addr_sel0});

	// R17 read back as written
	assign rd_byte = r_reg.cfg[{r_reg.ptr, 3'b000} +: 8];

	always_comb
	begin
		r_next = r_reg;
		// R14 sync gated by enable
		// R15 edge chosen by polarity
		r_next.sync_pulse = r_reg.cfg[`PCRB_SYNC_EN_BIT]
			& (r_reg.cfg[`PCRB_SYNC_POL_BIT] ? sync_rise : sync_fall);
		// R02 reference source mux
		r_next.ref_div_in = r_reg.cfg[`PCRB_REF_SRC_BIT] ? ref_pin_in : osc_in;
		// R03 feedback source mux
		r_next.fbk_div_in = r_reg.cfg[`PCRB_FBK_SRC_BIT] ? post_div_in : vco_in;
		if (stop_seen)
		begin
			r_next.state = PCRB_IDLE;
			r_next.sda_drive = 1'b0;
		end
		else if (start_seen)
		begin
			r_next.state = PCRB_DEV_ADDR;
			r_next.cnt = 4'h0;
			r_next.sda_drive = 1'b0;
		end
		else
		begin
			unique case (r_reg.state)
				PCRB_IDLE:
				begin
					r_next.sda_drive = 1'b0;
				end
				PCRB_DEV_ADDR, PCRB_REG_ADDR, PCRB_WR_DATA:
				begin
					if (scl_rise)
					begin
						r_next.shreg = {r_reg.shreg[6:0], sda_in};
						r_next.cnt = r_reg.cnt + 4'h1;
					end
					else if (scl_fall && r_reg.cnt == `PCRB_BITS_PER_BYTE)
					begin
						r_next.cnt = 4'h0;
						r_next.sda_drive = 1'b1;
						if (r_reg.state == PCRB_DEV_ADDR)
						begin
							if (addr_match)
							begin
								r_next.rw = r_reg.shreg[0];
								r_next.state = PCRB_ACK_DEV;
							end
							else
							begin
								r_next.sda_drive = 1'b0;
								r_next.state = PCRB_IDLE;
							end
						end
						else if (r_reg.state == PCRB_REG_ADDR)
						begin
							r_next.ptr = r_reg.shreg[2:0];
							r_next.state = PCRB_ACK_REG;
						end
						else
						begin
							// R19 field live at acknowledge
							r_next.cfg[{r_reg.ptr, 3'b000} +: 8] = r_reg.shreg;
							// R18 pointer wraps in three bits
							r_next.ptr = r_reg.ptr + 3'h1;
							r_next.state = PCRB_ACK_WR;
						end
					end
				end
				PCRB_ACK_DEV:
				begin
					if (scl_fall)
					begin
						r_next.cnt = 4'h0;
						if (r_reg.rw)
						begin
							r_next.shreg = rd_byte;
							r_next.sda_drive = ~rd_byte[7];
							r_next.state = PCRB_RD_DATA;
						end
						else
						begin
							r_next.sda_drive = 1'b0;
							r_next.state = PCRB_REG_ADDR;
						end
					end
				end
				PCRB_ACK_REG, PCRB_ACK_WR:
				begin
					if (scl_fall)
					begin
						r_next.sda_drive = 1'b0;
						r_next.cnt = 4'h0;
						r_next.state = PCRB_WR_DATA;
					end
				end
				PCRB_RD_DATA:
				begin
					if (scl_rise)
						r_next.cnt = r_reg.cnt + 4'h1;
					else if (scl_fall)
					begin
						if (r_reg.cnt == `PCRB_BITS_PER_BYTE)
						begin
							r_next.sda_drive = 1'b0;
							// R18 advance after each byte
							r_next.ptr = r_reg.ptr + 3'h1;
							r_next.state = PCRB_RD_ACK;
						end
						else
						begin
							r_next.shreg = {r_reg.shreg[6:0], 1'b0};
							r_next.sda_drive = ~r_reg.shreg[6];
						end
					end
				end
				PCRB_RD_ACK:
				begin
					if (scl_rise)
						r_next.rw = ~sda_in;
					else if (scl_fall)
					begin
						r_next.cnt = 4'h0;
						if (r_reg.rw)
						begin
							r_next.shreg = rd_byte;
							r_next.sda_drive = ~rd_byte[7];
							r_next.state = PCRB_RD_DATA;
						end
						else
						begin
							r_next.sda_drive = 1'b0;
							r_next.state = PCRB_IDLE;
						end
					end
				end
				default:
				begin
					r_next.state = PCRB_IDLE;
					r_next.sda_drive = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys)
	begin
		// R16 cleared at power-up
		if (!rstn)
			r_reg <= '{state: PCRB_IDLE, cnt: 4'h0, shreg: 8'h00, ptr: 3'h0, rw: 1'b0,
				sda_drive: 1'b0, cfg: `PCRB_CFG_RESET, ref_div_in: 1'b0,
				fbk_div_in: 1'b0, sync_pulse: 1'b0};
		else
			r_reg <= r_next;
	end

	pcrb_field_decode u_decode (
		.clk_sys         (clk_sys),
		.rstn            (rstn),
		.pump_code       (pump_current_code),
		.res_code        (loop_resistor_code),
		.cap_code        (loop_capacitor_select),
		.post_one_code   (post_stage_one_code),
		.post_two_code   (post_stage_two_code),
		.post_three_code (post_stage_three_code),
		.pump_sel        (pump_current_sel),
		.res_sel         (loop_resistor_sel),
		.cap_large       (loop_cap_large),
		.post_one_mod    (post_one_modulus),
		.post_two_mod    (post_two_modulus),
		.post_three_mod  (post_three_modulus)
	);

	// The pin is open drain: only a low is ever driven.
	assign sda_out = 1'b0;
	assign sda_oe  = r_reg.sda_drive;

	assign ref_div_in = r_reg.ref_div_in;
	assign fbk_div_in = r_reg.fbk_div_in;
	assign sync_event = r_reg.sync_pulse;

	// R10 reference length field
	assign ref_divide_length = r_reg.cfg[`PCRB_REF_LEN_LSB +: `PCRB_REF_LEN_W];
	// R11 feedback length field
	assign feedback_divide_length = r_reg.cfg[`PCRB_FBK_LEN_LSB +: `PCRB_FBK_LEN_W];
	assign ref_source_select      = r_reg.cfg[`PCRB_REF_SRC_BIT];
	assign feedback_source_select = r_reg.cfg[`PCRB_FBK_SRC_BIT];
	// R04 first power-down control
	assign shutdown_first = r_reg.cfg[`PCRB_SHUTDOWN_ONE_BIT];
	// R05 second power-down control
	assign shutdown_second = r_reg.cfg[`PCRB_SHUTDOWN_TWO_BIT];
	// R06 output driver mode
	assign cmos_output_mode      = r_reg.cfg[`PCRB_CMOS_MODE_BIT];
	assign pump_current_code     = r_reg.cfg[`PCRB_PUMP_CODE_LSB +: 2];
	assign loop_resistor_code    = r_reg.cfg[`PCRB_RES_CODE_LSB +: 2];
	assign loop_capacitor_select = r_reg.cfg[`PCRB_CAP_SEL_BIT];
	assign post_stage_one_code   = r_reg.cfg[`PCRB_POST_ONE_LSB +: 4];
	assign post_stage_two_code   = r_reg.cfg[`PCRB_POST_TWO_LSB +: 4];
	assign post_stage_three_code = r_reg.cfg[`PCRB_POST_THREE_LSB +: 2];
	assign sync_input_enable     = r_reg.cfg[`PCRB_SYNC_EN_BIT];
	assign sync_edge_polarity    = r_reg.cfg[`PCRB_SYNC_POL_BIT];
endmodule // pcrb_top
`default_nettype wire

// file: tb/pcrb_top_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module pcrb_top_monitor (
	input  wire logic        clk_sys,                // clock
	input  wire logic        rstn,                   // reset
	input  wire logic        osc_in,                 // crystal feed
	input  wire logic        ref_pin_in,             // pin feed
	input  wire logic        ref_div_in,             // muxed feed
	input  wire logic        ref_source_select,      // source bit
	input  wire logic        vco_in,                 // oscillator feed
	input  wire logic        post_div_in,            // post divider feed
	input  wire logic        fbk_div_in,             // muxed feedback feed
	input  wire logic        feedback_source_select, // feedback source bit
	input  wire logic [11:0] ref_divide_length,      // ref length
	input  wire logic [1:0]  pump_current_code,      // pump code
	input  wire logic [3:0]  pump_current_sel,       // pump one-hot
	input  wire logic [1:0]  loop_resistor_code,     // resistor code
	input  wire logic [3:0]  loop_resistor_sel,      // resistor one-hot
	input  wire logic        loop_capacitor_select,  // cap bit
	input  wire logic        loop_cap_large,         // cap choice
	input  wire logic [3:0]  post_stage_one_code,    // post one code
	input  wire logic [4:0]  post_one_modulus,       // post one modulus
	input  wire logic [1:0]  post_stage_three_code,  // post three code
	input  wire logic [3:0]  post_three_modulus,     // post three modulus
	input  wire logic        sync_in,                // sync level
	input  wire logic        sync_input_enable,      // sync enable
	input  wire logic        sync_edge_polarity,     // sync polarity
	input  wire logic        sync_event              // sync pulse
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	logic [1:0] arm_reg = 2'b00;
	always_ff @(posedge clk_sys)
		arm_reg <= {arm_reg[0], 1'b1};
	sequence s_ran;
		$past(rstn);
	endsequence
	sequence s_sync_off;
		!sync_input_enable [*3];
	endsequence
	property p_ref_mux;
		s_ran |-> ref_div_in == ($past(ref_source_select) ? $past(ref_pin_in) : $past(osc_in));
	endproperty
	a_ref_mux: assert property (p_ref_mux) else $error("reference feed wrong");
	property p_fbk_mux;
		s_ran |-> fbk_div_in == ($past(feedback_source_select) ? $past(post_div_in) : $past(vco_in));
	endproperty
	a_fbk_mux: assert property (p_fbk_mux) else $error("feedback feed wrong");
	property p_pump;
		s_ran |-> pump_current_sel == (4'h1 << $past(pump_current_code));
	endproperty
	a_pump: assert property (p_pump) else $error("pump selection wrong");
	property p_res;
		s_ran |-> loop_resistor_sel == (4'h1 << $past(loop_resistor_code));
	endproperty
	a_res: assert property (p_res) else $error("resistor selection wrong");
	property p_cap;
		s_ran |-> loop_cap_large == $past(loop_capacitor_select);
	endproperty
	a_cap: assert property (p_cap) else $error("capacitor selection wrong");
	property p_post_one;
		s_ran |-> post_one_modulus == $past(post_stage_one_code) + 5'h01;
	endproperty
	a_post_one: assert property (p_post_one) else $error("post one modulus wrong");
	property p_post_three;
		s_ran |-> post_three_modulus == (4'h1 << $past(post_stage_three_code));
	endproperty
	a_post_three: assert property (p_post_three) else $error("post three modulus wrong");
	property p_sync_off;
		s_sync_off |-> !sync_event;
	endproperty
	a_sync_off: assert property (p_sync_off) else $error("sync pulse while disabled");
	property p_sync_pol;
		sync_event |-> (sync_edge_polarity ? $past(sync_in) : !$past(sync_in));
	endproperty
	a_sync_pol: assert property (p_sync_pol) else $error("sync pulse on wrong edge");
	property p_reset;
		@(posedge clk_sys) disable iff (1'b0)
		arm_reg[1] && !$past(rstn) && !$past(rstn, 2) |->
			ref_divide_length == 12'h000 && pump_current_sel == 4'h1 && post_three_modulus == 4'h1 && !sync_event;
	endproperty
	a_reset: assert property (p_reset) else $error("outputs not cleared in reset");
endmodule // pcrb_top_monitor
bind pcrb_top pcrb_top_monitor u_mon (.clk_sys, .rstn, .osc_in, .ref_pin_in, .ref_div_in, .ref_source_select,
	.vco_in, .post_div_in, .fbk_div_in, .feedback_source_select,
	.ref_divide_length, .pump_current_code, .pump_current_sel, .loop_resistor_code, .loop_resistor_sel,
	.loop_capacitor_select, .loop_cap_large, .post_stage_one_code, .post_one_modulus, .post_stage_three_code,
	.post_three_modulus, .sync_in, .sync_input_enable, .sync_edge_polarity, .sync_event);
`default_nettype wire

// file: tb/pcrb_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module pcrb_host_model (
	input  wire logic       clk_sys,   // clock
	input  wire logic       sda_in,    // resolved data line
	output logic            scl_out,   // serial clock
	output logic            sda_low,   // 1 pulls data low
	output logic      [7:0] rd_byte,   // byte just read
	output logic            rd_strobe  // one-cycle read mark
);
	initial
	begin
		scl_out = 1'b1;
		sda_low = 1'b0;
		rd_byte = 8'h00;
		rd_strobe = 1'b0;
	end
	// Each level stands four cycles, three more than the slave needs.
	task automatic hold();
		repeat (4) @(posedge clk_sys);
	endtask
	task automatic put_bit(input logic b);
		sda_low <= !b;
		hold();
		scl_out <= 1'b1;
		hold();
		scl_out <= 1'b0;
		hold();
	endtask
	task automatic get_bit(output logic b);
		sda_low <= 1'b0;
		hold();
		scl_out <= 1'b1;
		hold();
		b = sda_in;
		scl_out <= 1'b0;
		hold();
	endtask
	task automatic start();
		sda_low <= 1'b0;
		hold();
		scl_out <= 1'b1;
		hold();
		sda_low <= 1'b1;
		hold();
		scl_out <= 1'b0;
		hold();
	endtask
	task automatic stop();
		sda_low <= 1'b1;
		hold();
		scl_out <= 1'b1;
		hold();
		sda_low <= 1'b0;
		hold();
	endtask
	task automatic send(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--)
			put_bit(d[i]);
		get_bit(b);
		ack = !b;
	endtask
	// A low answer acknowledges; the last byte is refused to end the read.
	task automatic take(input logic last, output logic [7:0] d);
		for (int i = 7; i >= 0; i--)
			get_bit(d[i]);
		rd_byte <= d;
		rd_strobe <= 1'b1;
		@(posedge clk_sys);
		rd_strobe <= 1'b0;
		put_bit(last);
	endtask
endmodule // pcrb_host_model
`default_nettype wire

// file: tb/pll_config_register_bank_tb.sv
`timescale 1ns/1ns
`default_nettype none
module pll_config_register_bank_tb;
	localparam logic [4:0] DEV_HI = 5'h0b;
	localparam logic [63:0] KEEP = 64'h0023_73ff_ffff_ffff;
	logic clk_sys = 1'b0, rstn = 1'b0, sync_in = 1'b0;
	logic osc_in = 1'b0, ref_pin_in = 1'b0, vco_in = 1'b0, post_div_in = 1'b0;
	logic [1:0] a_sel = 2'b00;
	logic scl_w, sda_low, sda_out, sda_oe, rd_strobe, ref_div_in, fbk_div_in, ref_source_select;
	logic feedback_source_select, shutdown_first, shutdown_second, cmos_output_mode, loop_capacitor_select;
	logic sync_input_enable, sync_edge_polarity, loop_cap_large, sync_event, ack;
	logic [1:0] pump_current_code, loop_resistor_code, post_stage_three_code;
	logic [3:0] post_stage_one_code, post_stage_two_code, pump_current_sel, loop_resistor_sel, post_three_modulus;
	logic [4:0] post_one_modulus, post_two_modulus;
	logic [7:0] rd_byte, d;
	logic [11:0] ref_divide_length;
	logic [13:0] feedback_divide_length;
	logic [63:0] cfg;
	logic [6:0] dev;
	logic [7:0] exp_q[$];
	int bad_count = 0, compares = 0, cycles = 0, events = 0;
	wire logic sda_w = !(sda_low | sda_oe);
	pcrb_host_model host (.clk_sys, .sda_in(sda_w), .scl_out(scl_w), .sda_low, .rd_byte, .rd_strobe);
	pcrb_top #(.DEV_ADDR_HIGH(DEV_HI)) uut (.clk_sys, .rstn, .scl_in(scl_w), .sda_in(sda_w), .sda_out, .sda_oe,
		.addr_sel0(a_sel[0]), .addr_sel1(a_sel[1]), .sync_in, .osc_in, .ref_pin_in, .vco_in, .post_div_in,
		.ref_div_in, .fbk_div_in, .ref_divide_length, .feedback_divide_length, .ref_source_select,
		.feedback_source_select, .shutdown_first, .shutdown_second, .cmos_output_mode, .pump_current_code,
		.loop_resistor_code, .loop_capacitor_select, .post_stage_one_code, .post_stage_two_code,
		.post_stage_three_code, .sync_input_enable, .sync_edge_polarity, .pump_current_sel, .loop_resistor_sel,
		.loop_cap_large, .post_one_modulus, .post_two_modulus, .post_three_modulus, .sync_event);
	always #2 clk_sys = !clk_sys;
	task automatic finish_test();
		$display("checks %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	always @(posedge clk_sys)
	begin
		{osc_in, ref_pin_in, vco_in, post_div_in} <= 4'($urandom);
		cycles++;
		if (sync_event === 1'b1)
			events++;
		if (cycles == 30000)
		begin
			bad_count++;
			finish_test();
		end
	end
	always @(posedge clk_sys)
		if (rd_strobe === 1'b1)
			chk(rd_byte, exp_q.pop_front());
	task automatic do_reset();
		rstn <= 1'b0;
		repeat (16) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
	endtask
	task automatic wr(input logic [7:0] r, input int n);
		host.start();
		host.send({dev, 1'b0}, ack);
		host.send(r, ack);
		for (int k = 0; k < n; k++)
			host.send(cfg[8 * ((r + k) % 8) +: 8], ack);
		chk(ack, 1'b1);
		host.stop();
	endtask
	task automatic rd(input logic [7:0] r, input int n);
		host.start();
		host.send({dev, 1'b0}, ack);
		host.send(r, ack);
		host.start();
		host.send({dev, 1'b1}, ack);
		for (int k = 0; k < n; k++)
		begin
			exp_q.push_back(cfg[8 * ((r + k) % 8) +: 8]);
			host.take(k == n - 1, d);
		end
		host.stop();
		chk(exp_q.size(), 0);
	endtask
	initial
	begin
		void'($urandom(32'hcb3e));
		dev = {DEV_HI, 2'($urandom)};
		a_sel <= dev[1:0];
		do_reset();
		chk({ref_divide_length, feedback_divide_length, pump_current_sel}, 30'h1);
		for (int p = 0; p < 4; p++)
		begin
			// Reserved bits stay zero and post codes stay in 0 to 11.
			cfg = {$urandom, $urandom} & KEEP;
			cfg[19:16] = 4'($urandom % 12);
			cfg[23:20] = 4'($urandom % 12);
			cfg[41:40] = 2'(p);
			cfg[45:44] = 2'(3 - p);
			cfg[15:14] = 2'(p);
			// Both feed selections are visited so the mux checks see each source.
			cfg[12] = p[0];
			cfg[38] = p[1];
			wr(8'h00, 8);
			repeat (3) @(posedge clk_sys);
			chk({cmos_output_mode, feedback_source_select, feedback_divide_length, post_stage_two_code,
				post_stage_one_code, post_stage_three_code, shutdown_first, ref_source_select,
				ref_divide_length}, cfg[39:0]);
			chk({shutdown_second, sync_edge_polarity, sync_input_enable, loop_capacitor_select, loop_resistor_code,
				pump_current_code}, {cfg[53], cfg[49:48], cfg[46:44], cfg[41:40]});
			chk({post_two_modulus, post_one_modulus}, {cfg[23:20] + 5'h01, cfg[19:16] + 5'h01});
			chk({pump_current_sel, loop_resistor_sel}, {4'h1 << cfg[41:40], 4'h1 << cfg[45:44]});
			chk({loop_cap_large, post_three_modulus}, {cfg[46], 4'h1 << cfg[15:14]});
		end
		$display("test field write done");
		host.start();
		host.send({dev ^ 7'h01, 1'b0}, ack);
		chk(ack, 1'b0);
		host.stop();
		$display("test wrong address done");
		for (int m = 0; m < 3; m++)
		begin
			cfg[49:48] = (m == 0) ? 2'b00 : (m == 1) ? 2'b01 : 2'b11;
			wr(8'h06, 1);
			events = 0;
			sync_in <= 1'b1;
			repeat (10) @(posedge clk_sys);
			chk(events, m == 2);
			sync_in <= 1'b0;
			repeat (10) @(posedge clk_sys);
			chk(events, m > 0);
		end
		$display("test sync done");
		rd(8'h05, 8);
		$display("test wrapped read done");
		do_reset();
		cfg = 64'h0000_0000_0000_0000;
		rd(8'h03, 2);
		$display("test second reset done");
		finish_test();
	end
endmodule // pll_config_register_bank_tb
`default_nettype wire
